// *** hw/oneshot_timer_map.vh ***
// register offsets, field positions and reset values of the one-shot timer block
`ifndef ONESHOT_TIMER_MAP_VH
`define ONESHOT_TIMER_MAP_VH
`define OFS_TIMER_CONTROL   4'h0
`define OFS_TIMER_MODE      4'h1
`define OFS_PERIOD_VALUE    4'h2
`define OFS_COMPARE_LOW     4'h3
`define OFS_COMPARE_HIGH    4'h4
`define OFS_CCP_CONTROL     4'h5
`define OFS_STATUS          4'h6
`define OFS_TIMER_COUNT     4'h7
`define BIT_RUN             7
`define BIT_FLAG            0
`define BIT_CMP_OUT         1
`define BIT_SLEEP           2
`define BIT_WAKE            3
`define BIT_TRIG_SEL        4
`define MODE_ONESHOT        5'h08
`define CCP_MODE_OFF        4'h0
`define CCP_MODE_COMPARE    4'h8
`define CCP_MODE_PWM        4'hc
`define RST_TIMER_CONTROL   8'h00
`define RST_TIMER_MODE      5'h00
`define RST_PERIOD_VALUE    8'hff
`define RST_BYTE            8'h00
`endif

// *** hw/event_scaler.v ***
// prescaler and postscaler stage of the one-shot timer
`timescale 1ns/10ps
module event_scaler (
    input  wire       clk_i,     // instruction clock
    input  wire       clear_i,   // hold in reset while timer is off
    input  wire [2:0] pre_sel_i, // prescale code, 2^code
    input  wire [3:0] post_sel_i,// postscale code, code+1
    input  wire       match_i,   // period match event
    output reg        tick_o,    // prescaled count enable
    output reg        event_o    // postscaled output event
);
    reg [6:0] pre_count;  // prescale counter
    reg [3:0] post_count; // postscale counter
    wire [6:0] pre_limit; // terminal prescale value
    assign pre_limit = (7'h01 << pre_sel_i) - 7'h01;

    // prescaler: divide clock by powers of two
    always @(posedge clk_i) begin
        if (clear_i) begin
            pre_count <= 7'h00;
            tick_o    <= 1'b0;
        end else if (pre_count >= pre_limit) begin
            pre_count <= 7'h00;
            tick_o    <= 1'b1;
        end else begin
            pre_count <= pre_count + 7'h01;
            tick_o    <= 1'b0;
        end
    end

    // postscaler: one event per code+1 matches
    always @(posedge clk_i) begin
        if (clear_i) begin
            post_count <= 4'h0;
            event_o    <= 1'b0;
        end else if (match_i && post_count >= post_sel_i) begin
            post_count <= 4'h0;
            event_o    <= 1'b1;
        end else begin
            if (match_i)
                post_count <= post_count + 4'h1;
            event_o <= 1'b0;
        end
    end
endmodule // event_scaler

// *** hw/oneshot_timer_ccp.v ***
// one-shot period timer coupled to a capture/compare/pwm output, avalon-mm slave
// Overview of operation
// - one-shot period match clears count and run
// - mode 01000 selects software-start one-shot
// - clearing run zeroes counter, cycle restarts from zero on run
// - pulse rises with the run-bit write
// - clearing run while active extends pulse
// - pulse ends at compare match, stays off
// - run cleared after match leaves pulse off
// - new cycle only on a run-bit write while run is clear
// - run is control bit 7, hardware cleared
// - postscale bits 3:0 divide by value+1
// - zero control write clears compare latch
// - compare and pwm modes set interrupt flag on event
// - flag plus match issues conversion trigger
// - compare change cancels pending timer reset
// - sleep compare only with running timer, wakes
// - output also offered to internal peripherals
// - pwm identical for every unit
// - pulse width resolution up to ten bits; count resets at the 8-bit period match, so widths above 255 never match
//
// Added by the designer: the Avalon-MM slave port and the register offsets.
`timescale 1ns/10ps
`include "oneshot_timer_map.vh"
module oneshot_timer_ccp (
    input  wire        CLOCK_I,          // 50 mhz instruction clock
    input  wire        RST_B_I,          // synchronous reset, active low
    input  wire [3:0]  AVS_ADDRESS_I,    // word index
    input  wire        AVS_READ_I,       // read strobe
    input  wire        AVS_WRITE_I,      // write strobe
    input  wire [31:0] AVS_WRITEDATA_I,  // write data
    input  wire [3:0]  AVS_BYTEENABLE_I, // byte lanes
    output reg  [31:0] AVS_READDATA_O,   // read data
    output reg         AVS_WAITREQUEST_O,// stall until answered
    input  wire [15:0] COMPANION_COUNT_I,// companion 16-bit timer value
    input  wire        COMPANION_RUN_I,  // companion timer running (pin domain)
    input  wire        SLEEP_I,          // device in sleep (pin domain)
    output reg         COMPANION_RESET_O,// reset pulse to companion timer
    output reg         CONV_TRIGGER_O,   // auto-conversion trigger pulse
    output reg         WAKE_O,           // wake request
    output reg         PWM_PIN_O,        // drive to output pin
    output reg         CCP_INTERNAL_O,   // same signal for peripherals
    output reg         TIMER_EVENT_O     // postscaled timer output event
);
    // registers
    reg [7:0]  timer_control;   // run, prescale, postscale
    reg [4:0]  timer_mode;      // mode field
    reg [7:0]  period_value;    // period compare
    reg [7:0]  compare_value_low;  // compare low byte
    reg [7:0]  compare_value_high; // compare high byte
    reg [7:0]  capture_compare_control; // bit3:0 mode, bit4 trigger select
    reg        capture_compare_flag;    // sticky event flag
    reg        wake_enable;     // sleep wake enable
    reg [9:0]  timer_count;     // main count
    reg        pulse_active;    // pwm drive state
    reg        compare_latch;   // compare output latch
    reg        trig_pending;    // compare match seen, reset due next edge
    reg [15:0] cmp_at_trigger;  // compare pair at trigger edge
    reg        run_q;           // run bit last cycle
    reg        answered;        // bus answer cycle
    reg [1:0]  sleep_sync;      // pin synchroniser
    reg [1:0]  comp_run_sync;   // pin synchroniser

    wire        run = timer_control[`BIT_RUN];
    wire        oneshot = (timer_mode == `MODE_ONESHOT);
    wire [3:0]  ccp_mode = capture_compare_control[3:0];
    wire        pwm_mode = (ccp_mode == `CCP_MODE_PWM);
    wire        cmp_mode = (ccp_mode == `CCP_MODE_COMPARE);
    wire [15:0] compare_pair = {compare_value_high, compare_value_low};
    wire        tick;           // prescaled enable
    wire        post_event;     // postscaled event
    wire        period_match = run && tick && (timer_count[7:0] == period_value);
    wire [9:0]  width10 = {compare_value_high[1:0], compare_value_low};
    wire        width_match = run && (timer_count == width10);
    wire        asleep = sleep_sync[1];
    wire        cmp_clock_ok = !asleep || comp_run_sync[1];
    wire        cmp_match = cmp_mode && cmp_clock_ok && (COMPANION_COUNT_I == compare_pair);
    wire        acc = (AVS_READ_I || AVS_WRITE_I) && !answered;
    wire        wr = AVS_WRITE_I && !answered && AVS_BYTEENABLE_I[0];
    wire        wr_ctl = wr && (AVS_ADDRESS_I == `OFS_TIMER_CONTROL);
    wire        wr_ccp = wr && (AVS_ADDRESS_I == `OFS_CCP_CONTROL);
    wire        run_set = wr_ctl && AVS_WRITEDATA_I[`BIT_RUN] && !run;

    // prescale and postscale stage, cleared while off
    event_scaler u_scaler (
        .clk_i      (CLOCK_I),
        .clear_i    (!run || !RST_B_I),
        .pre_sel_i  (timer_control[6:4]),
        .post_sel_i (timer_control[3:0]),
        .match_i    (period_match),
        .tick_o     (tick),
        .event_o    (post_event)
    );

    // pin input synchronisers
    always @(posedge CLOCK_I) begin
        if (!RST_B_I) begin
            sleep_sync    <= 2'h0;
            comp_run_sync <= 2'h0;
        end else begin
            sleep_sync    <= {sleep_sync[0], SLEEP_I};
            comp_run_sync <= {comp_run_sync[0], COMPANION_RUN_I};
        end
    end

    // bus handshake: one wait cycle, answer on second
    always @(posedge CLOCK_I) begin
        if (!RST_B_I) begin
            answered          <= 1'b0;
            AVS_WAITREQUEST_O <= 1'b1;
        end else begin
            answered          <= acc;
            AVS_WAITREQUEST_O <= !acc;
        end
    end

    // read mux, registered
    always @(posedge CLOCK_I) begin
        if (!RST_B_I)
            AVS_READDATA_O <= 32'h0000_0000;
        else if (AVS_READ_I && acc) begin
            case (AVS_ADDRESS_I)
                `OFS_TIMER_CONTROL: AVS_READDATA_O <= {24'h000000, timer_control};
                `OFS_TIMER_MODE:    AVS_READDATA_O <= {27'h0000000, timer_mode};
                `OFS_PERIOD_VALUE:  AVS_READDATA_O <= {24'h000000, period_value};
                `OFS_COMPARE_LOW:   AVS_READDATA_O <= {24'h000000, compare_value_low};
                `OFS_COMPARE_HIGH:  AVS_READDATA_O <= {24'h000000, compare_value_high};
                `OFS_CCP_CONTROL:   AVS_READDATA_O <= {24'h000000, capture_compare_control};
                `OFS_STATUS:        AVS_READDATA_O <= {28'h0000000, wake_enable, asleep,
                                                       compare_latch, capture_compare_flag};
                `OFS_TIMER_COUNT:   AVS_READDATA_O <= {22'h000000, timer_count};
                default:            AVS_READDATA_O <= 32'h0000_0000; // unmapped reads zero
            endcase
        end
    end

    // software registers and run bit
    always @(posedge CLOCK_I) begin
        if (!RST_B_I) begin
            timer_control           <= `RST_TIMER_CONTROL;
            timer_mode              <= `RST_TIMER_MODE;
            period_value            <= `RST_PERIOD_VALUE;
            compare_value_low       <= `RST_BYTE;
            compare_value_high      <= `RST_BYTE;
            capture_compare_control <= `RST_BYTE;
            wake_enable             <= 1'b0;
        end else begin
            if (wr_ctl)
                timer_control <= AVS_WRITEDATA_I[7:0];
            else if (oneshot && period_match)
                timer_control[`BIT_RUN] <= 1'b0;
            if (wr && AVS_ADDRESS_I == `OFS_TIMER_MODE)
                timer_mode <= AVS_WRITEDATA_I[4:0];
            if (wr && AVS_ADDRESS_I == `OFS_PERIOD_VALUE)
                period_value <= AVS_WRITEDATA_I[7:0];
            if (wr && AVS_ADDRESS_I == `OFS_COMPARE_LOW)
                compare_value_low <= AVS_WRITEDATA_I[7:0];
            if (wr && AVS_ADDRESS_I == `OFS_COMPARE_HIGH)
                compare_value_high <= AVS_WRITEDATA_I[7:0];
            if (wr_ccp)
                capture_compare_control <= AVS_WRITEDATA_I[7:0];
            if (wr && AVS_ADDRESS_I == `OFS_STATUS)
                wake_enable <= AVS_WRITEDATA_I[`BIT_WAKE];
        end
    end

    // main counter, held at zero while off
    always @(posedge CLOCK_I) begin
        if (!RST_B_I || !run)
            timer_count <= 10'h000;
        else if (period_match)
            timer_count <= 10'h000;
        else if (tick)
            timer_count <= timer_count + 10'h001;
    end

    // pwm pulse state
    always @(posedge CLOCK_I) begin
        run_q <= RST_B_I && run;
        if (!RST_B_I)
            pulse_active <= 1'b0;
        else if (!pwm_mode)
            pulse_active <= 1'b0;
        else if (run_set)
            pulse_active <= 1'b1;
        else if (!run)
            pulse_active <= pulse_active;
        else if (width_match && run_q)
            pulse_active <= 1'b0;
    end

    // compare latch, flag, trigger and companion reset
    always @(posedge CLOCK_I) begin
        if (!RST_B_I) begin
            compare_latch        <= 1'b0;
            capture_compare_flag <= 1'b0;
            trig_pending         <= 1'b0;
            cmp_at_trigger       <= 16'h0000;
            CONV_TRIGGER_O       <= 1'b0;
            COMPANION_RESET_O    <= 1'b0;
        end else begin
            if (wr_ccp && AVS_WRITEDATA_I[7:0] == 8'h00)
                compare_latch <= 1'b0;
            else if (cmp_match)
                compare_latch <= 1'b1;
            // hardware set wins over software clear
            if (cmp_match || (pwm_mode && period_match))
                capture_compare_flag <= 1'b1;
            else if (wr && AVS_ADDRESS_I == `OFS_STATUS && !AVS_WRITEDATA_I[`BIT_FLAG])
                capture_compare_flag <= 1'b0;
            CONV_TRIGGER_O <= cmp_match && capture_compare_flag &&
                              capture_compare_control[`BIT_TRIG_SEL];
            trig_pending   <= cmp_match;
            cmp_at_trigger <= compare_pair;
            COMPANION_RESET_O <= trig_pending && (cmp_at_trigger == compare_pair);
        end
    end

    // outputs from flip-flops
    always @(posedge CLOCK_I) begin
        if (!RST_B_I) begin
            PWM_PIN_O      <= 1'b0;
            CCP_INTERNAL_O <= 1'b0;
            WAKE_O         <= 1'b0;
            TIMER_EVENT_O  <= 1'b0;
        end else begin
            PWM_PIN_O      <= pwm_mode ? (pulse_active || run_set) : compare_latch;
            CCP_INTERNAL_O <= pwm_mode ? (pulse_active || run_set) : compare_latch;
            WAKE_O         <= asleep && wake_enable && cmp_match;
            TIMER_EVENT_O  <= post_event;
        end
    end
endmodule // oneshot_timer_ccp

// *** verif/oneshot_timer_monitor.sv ***
// assertion checker for the one-shot timer block ports
`timescale 1ns/10ps
`include "oneshot_timer_map.vh"
module oneshot_timer_monitor (
    input wire        CLOCK_I,
    input wire        RST_B_I,
    input wire [3:0]  AVS_ADDRESS_I,
    input wire [3:0]  AVS_BYTEENABLE_I,
    input wire        AVS_READ_I,
    input wire        AVS_WRITE_I,
    input wire [31:0] AVS_READDATA_O,
    input wire        AVS_WAITREQUEST_O,
    input wire        COMPANION_RESET_O,
    input wire        CONV_TRIGGER_O,
    input wire        WAKE_O,
    input wire        PWM_PIN_O,
    input wire        CCP_INTERNAL_O,
    input wire        TIMER_EVENT_O
);
    default clocking cb @(posedge CLOCK_I); endclocking
    default disable iff (!RST_B_I);
    // request seen while the slave still waits
    sequence s_taken; (AVS_READ_I || AVS_WRITE_I) && AVS_WAITREQUEST_O; endsequence
    // one low cycle, then back to waiting
    sequence s_answer; !AVS_WAITREQUEST_O ##1 AVS_WAITREQUEST_O; endsequence
    property p_answer; s_taken |=> s_answer; endproperty
    a_answer: assert property (p_answer) else $error("bus answer late or long");
    property p_no_spur; $fell(AVS_WAITREQUEST_O) |-> $past(AVS_READ_I || AVS_WRITE_I); endproperty
    a_no_spur: assert property (p_no_spur) else $error("answer without request");
    property p_rd_hold; (!AVS_READ_I && $past(!AVS_READ_I)) |-> $stable(AVS_READDATA_O); endproperty
    a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
    property p_internal; CCP_INTERNAL_O == PWM_PIN_O; endproperty
    a_internal: assert property (p_internal) else $error("internal copy differs");
    property p_trig; CONV_TRIGGER_O |=> !CONV_TRIGGER_O; endproperty
    a_trig: assert property (p_trig) else $error("trigger too long");
    property p_event; TIMER_EVENT_O |=> !TIMER_EVENT_O; endproperty
    a_event: assert property (p_event) else $error("event too long");
    // a trigger is followed by the companion reset unless the compare pair was written on the trigger edge
    property p_comp_rst;
        (CONV_TRIGGER_O && !$past(AVS_WRITE_I && AVS_WAITREQUEST_O && AVS_BYTEENABLE_I[0] &&
            (AVS_ADDRESS_I == `OFS_COMPARE_LOW || AVS_ADDRESS_I == `OFS_COMPARE_HIGH)))
        |=> COMPANION_RESET_O;
    endproperty
    a_comp_rst: assert property (p_comp_rst) else $error("companion reset untriggered");
    property p_wake; WAKE_O |=> !WAKE_O; endproperty
    a_wake: assert property (p_wake) else $error("wake too long");
endmodule // oneshot_timer_monitor
bind oneshot_timer_ccp oneshot_timer_monitor u_mon (.CLOCK_I(CLOCK_I), .RST_B_I(RST_B_I),
    .AVS_ADDRESS_I(AVS_ADDRESS_I), .AVS_BYTEENABLE_I(AVS_BYTEENABLE_I),
    .AVS_READ_I(AVS_READ_I), .AVS_WRITE_I(AVS_WRITE_I), .AVS_READDATA_O(AVS_READDATA_O),
    .AVS_WAITREQUEST_O(AVS_WAITREQUEST_O), .COMPANION_RESET_O(COMPANION_RESET_O),
    .CONV_TRIGGER_O(CONV_TRIGGER_O), .WAKE_O(WAKE_O), .PWM_PIN_O(PWM_PIN_O),
    .CCP_INTERNAL_O(CCP_INTERNAL_O), .TIMER_EVENT_O(TIMER_EVENT_O));

// *** verif/companion_timer_model.sv ***
// companion 16-bit timer model feeding the count and run inputs
`timescale 1ns/10ps
module companion_timer_model (
    input  wire        clk_i,   // instruction clock
    input  wire        enable_i,// count enable from the bench
    input  wire        reset_i, // reset pulse from the block
    output reg  [15:0] count_o, // running count
    output wire        run_o    // running flag
);
    assign run_o = enable_i;
    initial count_o = 16'h0000;
    // synchronous timer mode on the instruction clock
    always @(posedge clk_i) begin
        if (reset_i || !enable_i) begin
            count_o <= 16'h0000;
        end else begin
            count_o <= count_o + 16'h0001;
        end
    end
endmodule // companion_timer_model

// *** verif/oneshot_timer_ccp_test.sv ***
// self-checking testbench for the one-shot timer block
`timescale 1ns/10ps
`include "oneshot_timer_map.vh"
`define CHK(nm, ex, got) begin check_count++; if ((got) !== (ex)) begin err_total++; \
    $display("FAIL %s expected %h seen %h", nm, ex, got); end end
module oneshot_timer_ccp_test;
    reg         clk = 1'b0;     // bench clock
    reg         rst_b = 1'b0;   // reset, active low
    reg  [3:0]  addr = 4'h0;
    reg         rd = 1'b0;
    reg         wr = 1'b0;
    reg  [31:0] wdata = 32'h0;
    reg  [3:0]  be = 4'h0;
    reg         sleep = 1'b0;
    reg         comp_en = 1'b0; // companion timer enable
    wire [31:0] rdata;
    wire [15:0] comp_cnt;
    wire        waitreq, comp_run, comp_rst, trig, wake, pwm, internal, tev;
    reg  [7:0]  rv;             // last byte read
    integer     err_total = 0;
    integer     check_count = 0;
    integer     cycles = 0;
    integer     n, hi, h0;
    always #10 clk = ~clk;
    // pulse pin taken straight to the load side as a driven output
    oneshot_timer_ccp DUT (.CLOCK_I(clk), .RST_B_I(rst_b), .AVS_ADDRESS_I(addr), .AVS_READ_I(rd),
        .AVS_WRITE_I(wr), .AVS_WRITEDATA_I(wdata), .AVS_BYTEENABLE_I(be), .AVS_READDATA_O(rdata),
        .AVS_WAITREQUEST_O(waitreq), .COMPANION_COUNT_I(comp_cnt), .COMPANION_RUN_I(comp_run),
        .SLEEP_I(sleep), .COMPANION_RESET_O(comp_rst), .CONV_TRIGGER_O(trig), .WAKE_O(wake),
        .PWM_PIN_O(pwm), .CCP_INTERNAL_O(internal), .TIMER_EVENT_O(tev));
    companion_timer_model u_comp (.clk_i(clk), .enable_i(comp_en), .reset_i(comp_rst),
        .count_o(comp_cnt), .run_o(comp_run));
    // verdict and end of run
    task complete_run;
        begin
            $display("checks %0d errors %0d", check_count, err_total);
            if (err_total == 0 && check_count > 0) begin
                $display("No errors found");
            end else begin
                $display("Errors were found");
            end
            $finish;
        end
    endtask
    // hang guard
    always @(posedge clk) begin
        cycles = cycles + 1;
        if (cycles == 20000) begin
            err_total = err_total + 1;
            complete_run;
        end
    end
    // hold the request until waitrequest is sampled low, then release
    task bus_wait;
        begin
            n = 0;
            @(posedge clk);
            while (waitreq !== 1'b0 && n < 100) begin
                @(posedge clk);
                n = n + 1;
            end
            rv = rdata[7:0];
            rd <= 1'b0;
            wr <= 1'b0;
            if (n >= 100) err_total = err_total + 1;
        end
    endtask
    task bus_write(input [3:0] a, input [7:0] d, input [3:0] lanes);
        begin
            @(posedge clk);
            addr <= a;
            wdata <= {24'h000000, d};
            be <= lanes;
            wr <= 1'b1;
            bus_wait;
        end
    endtask
    task bus_read(input [3:0] a);
        begin
            @(posedge clk);
            addr <= a;
            rd <= 1'b1;
            bus_wait;
        end
    endtask
    // bounded wait for the pulse pin to reach a level; hi counts cycles
    task wait_pin(input v);
        begin
            hi = 0;
            while (pwm !== v && hi < 2000) begin
                @(posedge clk);
                hi = hi + 1;
            end
        end
    endtask
    // reset values, unmapped place, disabled byte lane
    task t_regs;
        begin
            bus_read(`OFS_TIMER_CONTROL);
            `CHK("control reset", `RST_TIMER_CONTROL, rv)
            bus_read(`OFS_PERIOD_VALUE);
            `CHK("period reset", `RST_PERIOD_VALUE, rv)
            bus_write(4'h9, 8'h5a, 4'h1);
            bus_read(4'h9);
            `CHK("unmapped", 8'h00, rv)
            bus_write(`OFS_PERIOD_VALUE, 8'h33, 4'h0);
            bus_read(`OFS_PERIOD_VALUE);
            `CHK("lane off", `RST_PERIOD_VALUE, rv)
        end
    endtask
    // plain one-shot pulse with period 10 and width 3
    task t_oneshot;
        begin
            bus_write(`OFS_TIMER_MODE, {3'b000, `MODE_ONESHOT}, 4'h1);
            bus_read(`OFS_TIMER_MODE);
            `CHK("mode", 8'h08, rv)
            bus_write(`OFS_PERIOD_VALUE, 8'h0a, 4'h1);
            bus_write(`OFS_COMPARE_LOW, 8'h03, 4'h1);
            bus_write(`OFS_COMPARE_HIGH, 8'h00, 4'h1);
            bus_write(`OFS_CCP_CONTROL, {4'h0, `CCP_MODE_PWM}, 4'h1);
            bus_write(`OFS_TIMER_CONTROL, 8'h80, 4'h1);
            `CHK("pulse start", 1'b1, pwm)
            wait_pin(1'b0);
            h0 = hi;
            `CHK("pulse end", 1'b1, hi < 20)
            n = 0;
            repeat (60) begin
                @(posedge clk);
                if (tev === 1'b1) n = n + 1;
            end
            `CHK("events", 1, n)
            `CHK("pulse off", 1'b0, pwm)
            bus_read(`OFS_TIMER_CONTROL);
            `CHK("run cleared", 8'h00, rv)
            bus_read(`OFS_TIMER_COUNT);
            `CHK("count zero", 8'h00, rv)
        end
    endtask
    // run cleared while the pulse is active, then resumed
    task t_pause;
        begin
            bus_write(`OFS_COMPARE_LOW, 8'h08, 4'h1);
            bus_write(`OFS_TIMER_CONTROL, 8'h80, 4'h1);
            bus_write(`OFS_TIMER_CONTROL, 8'h00, 4'h1);
            repeat (20) @(posedge clk);
            `CHK("pulse held", 1'b1, pwm)
            bus_write(`OFS_TIMER_CONTROL, 8'h80, 4'h1);
            wait_pin(1'b0);
            `CHK("resumed end", 1'b1, hi < 40)
            repeat (40) @(posedge clk);
            bus_read(`OFS_TIMER_CONTROL);
            `CHK("cycle done", 8'h00, rv)
            `CHK("stays off", 1'b0, pwm)
        end
    endtask
    // prescale 1:2 must lengthen the pulse
    task t_prescale;
        begin
            bus_write(`OFS_COMPARE_LOW, 8'h03, 4'h1);
            bus_write(`OFS_TIMER_CONTROL, 8'h90, 4'h1);
            wait_pin(1'b0);
            `CHK("prescaled width", 1'b1, hi > h0)
            repeat (80) @(posedge clk);
            bus_read(`OFS_TIMER_CONTROL);
            `CHK("prescaled done", 8'h10, rv)
        end
    endtask
    // compare match with trigger, companion reset, sleep wake, latch clear
    task t_compare;
        begin
            bus_write(`OFS_COMPARE_LOW, 8'h20, 4'h1);
            bus_write(`OFS_CCP_CONTROL, {4'h1, `CCP_MODE_COMPARE}, 4'h1);
            comp_en <= 1'b1;
            n = 0;
            while (trig !== 1'b1 && n < 300) begin
                @(posedge clk);
                n = n + 1;
            end
            `CHK("trigger", 1'b1, trig)
            @(posedge clk);
            `CHK("companion reset", 1'b1, comp_rst)
            bus_read(`OFS_STATUS);
            `CHK("flag", 1'b1, rv[`BIT_FLAG])
            `CHK("latch set", 1'b1, rv[`BIT_CMP_OUT])
            sleep <= 1'b1;
            bus_write(`OFS_STATUS, 8'h08, 4'h1);
            n = 0;
            while (wake !== 1'b1 && n < 300) begin
                @(posedge clk);
                n = n + 1;
            end
            `CHK("wake", 1'b1, wake)
            sleep <= 1'b0;
            comp_en <= 1'b0;
            bus_write(`OFS_CCP_CONTROL, 8'h00, 4'h1);
            bus_read(`OFS_STATUS);
            `CHK("latch low", 1'b0, rv[`BIT_CMP_OUT])
        end
    endtask
    // main sequence
    initial begin
        repeat (6) @(posedge clk);
        rst_b <= 1'b1;
        t_regs;
        t_oneshot;
        t_pause;
        t_prescale;
        t_compare;
        complete_run;
    end
endmodule // oneshot_timer_ccp_test
